// ===== design/pmta_pkg.sv
// Package for the program memory table access unit.
// Assumes one core instruction clock; offsets are AXI4-Lite byte addresses.
package pmta_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_PTR_LOW   = 8'h00;
  localparam logic [7:0] ADDR_PTR_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_LATCH     = 8'h08;
  localparam logic [7:0] ADDR_CMD       = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_RDDATA    = 8'h14;
  localparam logic [7:0] ADDR_IRQ       = 8'h18;

  // ****************************************************************
  // Command field positions
  // ****************************************************************
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_HIGH_BIT = 2;
  localparam int CMD_INC_BIT  = 3;
  localparam int CMD_EXT_BIT  = 4;

  // Irq register fields: enables [3:0], flags [7:4], global disable bit 8
  localparam int IRQ_FLAG_LSB = 4;
  localparam int IRQ_GLD_BIT  = 8;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [15:0] PTR_RESET   = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [3:0]  IRQ_RESET   = 4'h0;
  localparam logic [1:0]  SHORT_CYCLES = 2'h2;
  localparam logic [1:0]  AXI_OKAY     = 2'h0;
  localparam logic [1:0]  AXI_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    OP_NONE       = 2'h0,
    OP_LATCH_WR   = 2'h1,
    OP_TABLE_RD   = 2'h2,
    OP_TABLE_WR   = 2'h3
  } pmta_op_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH  = 3'b001,
    ST_SHORT  = 3'b011,
    ST_LONG   = 3'b010,
    ST_DONE   = 3'b110
  } pmta_state_t;

endpackage : pmta_pkg

// ===== design/pmta_sync.sv
// Two-flop synchroniser for a bus of pin levels.
// Assumes inputs arrive asynchronously to clk.
`timescale 1ns/1ps
module pmta_sync
  import pmta_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1_reg;

  // ****************************************************************
  // Synchroniser
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      dout       <= '0;
    end else begin
      stage1_reg <= din;
      dout       <= stage1_reg;
    end
  end

endmodule : pmta_sync

// ===== design/pmta_core.sv
// Table read and write unit between 16-bit program memory and 8-bit data.
// Assumes an AXI4-Lite master and a memory answering reads within the cycle.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// - Read copies latch byte, then reloads latch
// - Read fetches full word at pointer
// - Pointer increments when increment bit set
// - Internal write starts long write, halting
// - Only reset or enabled flagged source ends
// - Global disable never blocks termination
// - Vector only when global disable clear
// - Core source termination clears top flag
// - Vectoring clears core source flag
// - Pending core interrupt aborts write, clears flag
// - Peripheral flag stays set after vector
// - Disabled globally: peripheral ends, no vector
// - No programming voltage: two cycles, no change
// - External write takes two cycles
// - Separate read and write latches externally
// - First read after pointer load returns stale
// - Write loads latch byte, then writes word
// - Pointer is sixteen bits from two bytes
module pmta_core
  import pmta_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        programmingVoltage,
  input  wire logic [3:0]  irqFlagSet,
  output logic [15:0]      memAddr,
  output logic [15:0]      memWdata,
  input  wire logic [15:0] memRdata,
  output logic             memRd,
  output logic             memWrIntern,
  output logic             memWrExtern,
  output logic             executionHalted,
  output logic             vectorBranch
);

  // ****************************************************************
  // State
  // ****************************************************************
  pmta_state_t state_reg;
  pmta_state_t state_next;
  logic [15:0] ptr_reg;
  logic [15:0] rdLatch_reg;
  logic [15:0] wrLatch_reg;
  logic [7:0]  rdData_reg;
  logic [3:0]  irqEn_reg;
  logic [3:0]  irqFlag_reg;
  logic        glbIntDis_reg;
  logic        incr_reg;
  logic        ext_reg;
  logic [1:0]  cnt_reg;
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        progVoltSync;

  pmta_sync #(.W(1)) uProgVoltSync (
    .clk  (clk),
    .rst  (rst),
    .din  (programmingVoltage),
    .dout (progVoltSync)
  );

  // Flags 0..2 are core sources by priority, bit 3 peripheral
  function automatic logic [3:0] top_core(input logic [3:0] m);
    if (m[0]) begin
      return 4'h1;
    end else if (m[1]) begin
      return 4'h2;
    end else if (m[2]) begin
      return 4'h4;
    end
    return 4'h0;
  endfunction : top_core

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        wrFire   = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  wire        rdFire   = s_axi_arvalid && s_axi_arready;
  wire        awHeldNext = !wrFire && (awHeld_reg || (s_axi_awvalid && s_axi_awready));
  wire        wHeldNext  = !wrFire && (wHeld_reg || (s_axi_wvalid && s_axi_wready));
  wire        bvalidNext = wrFire || (s_axi_bvalid && !s_axi_bready);
  wire        rvalidNext = rdFire || (s_axi_rvalid && !s_axi_rready);
  wire        idle     = (state_reg == ST_IDLE);
  wire [7:0]  wByte    = wData_reg[7:0];
  wire        wLane0   = wStrb_reg[0];
  wire        hitLow   = wrFire && wLane0 && (awAddr_reg == ADDR_PTR_LOW);
  wire        hitHigh  = wrFire && wLane0 && (awAddr_reg == ADDR_PTR_HIGH);
  wire        hitLatch = wrFire && wLane0 && (awAddr_reg == ADDR_LATCH);
  wire        hitCmd   = wrFire && wLane0 && (awAddr_reg == ADDR_CMD) && idle;
  wire        hitIrq   = wrFire && (awAddr_reg == ADDR_IRQ);
  wire        wrMapped = (awAddr_reg == ADDR_PTR_LOW) || (awAddr_reg == ADDR_PTR_HIGH)
                      || (awAddr_reg == ADDR_LATCH) || (awAddr_reg == ADDR_CMD)
                      || (awAddr_reg == ADDR_IRQ);
  wire [1:0]  cmdOp    = wByte[CMD_OP_LSB +: 2];
  wire        cmdHigh  = wByte[CMD_HIGH_BIT];
  wire        cmdExt   = wByte[CMD_EXT_BIT];
  wire [3:0]  active   = irqEn_reg & irqFlag_reg;
  wire        coreHit  = |active[2:0];
  wire        terminate = |active;
  wire [3:0]  coreClr  = top_core(active);
  wire        startRd  = hitCmd && (cmdOp == OP_TABLE_RD);
  wire        startWr  = hitCmd && (cmdOp == OP_TABLE_WR);
  wire        abortWr  = startWr && !cmdExt && coreHit;
  wire        longWr   = startWr && !cmdExt && !coreHit && progVoltSync;
  wire [15:0] ptrInc   = ptr_reg + 16'h0001;
  wire        doneStep = (state_reg == ST_DONE);
  wire        endLong  = (state_reg == ST_LONG) && terminate;
  wire [15:0] wrWord   = cmdHigh ? {wData_reg[15:8], wrLatch_reg[7:0]}
                                 : {wrLatch_reg[15:8], wData_reg[15:8]};
  wire [31:0] rdMux    =
      (s_axi_araddr == ADDR_PTR_LOW)  ? {24'h000000, ptr_reg[7:0]} :
      (s_axi_araddr == ADDR_PTR_HIGH) ? {24'h000000, ptr_reg[15:8]} :
      (s_axi_araddr == ADDR_LATCH)    ? {16'h0000, wrLatch_reg} :
      (s_axi_araddr == ADDR_STATUS)   ? {29'h0, ext_reg, executionHalted, !idle} :
      (s_axi_araddr == ADDR_RDDATA)   ? {24'h000000, rdData_reg} :
      (s_axi_araddr == ADDR_IRQ)      ? {23'h0, glbIntDis_reg, irqFlag_reg, irqEn_reg} :
      32'h00000000;
  wire        rdMapped = (s_axi_araddr <= ADDR_IRQ) && (s_axi_araddr[1:0] == 2'h0)
                      && (s_axi_araddr != ADDR_CMD);

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h00000000;
      wStrb_reg  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= AXI_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeldNext && !bvalidNext;
      s_axi_wready  <= !wHeldNext && !bvalidNext;
      s_axi_arready <= !rvalidNext;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdMapped ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (startRd) begin
          state_next = ST_FETCH;
        end else if (longWr) begin
          state_next = ST_LONG;
        end else if (startWr && !abortWr) begin
          state_next = ST_SHORT;
        end
      end
      ST_FETCH: state_next = ST_DONE;
      ST_SHORT: state_next = (cnt_reg == SHORT_CYCLES - 2'h1) ? ST_DONE : ST_SHORT;
      ST_LONG:  state_next = terminate ? ST_DONE : ST_LONG;
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 2'h0;
      incr_reg  <= 1'b0;
      ext_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_reg == ST_IDLE) ? 2'h1 : cnt_reg + 2'h1;
      if (hitCmd) begin
        incr_reg <= wByte[CMD_INC_BIT];
        ext_reg  <= cmdExt;
      end
    end
  end

  // ****************************************************************
  // Pointer, latches and read data
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_reg     <= PTR_RESET;
      rdLatch_reg <= LATCH_RESET;
      wrLatch_reg <= LATCH_RESET;
      rdData_reg  <= 8'h00;
    end else begin
      if (hitLow) begin
        ptr_reg[7:0] <= wByte;
      end else if (hitHigh) begin
        ptr_reg[15:8] <= wByte;
      end else if (doneStep && incr_reg) begin
        ptr_reg <= ptrInc;
      end
      if (startRd) begin
        rdData_reg <= cmdHigh ? rdLatch_reg[15:8] : rdLatch_reg[7:0];
      end
      if (state_reg == ST_FETCH) begin
        rdLatch_reg <= memRdata;
      end
      if (hitLatch || (hitCmd && cmdOp == OP_LATCH_WR)) begin
        if (cmdHigh && !hitLatch) begin
          wrLatch_reg[15:8] <= wData_reg[15:8];
        end else begin
          wrLatch_reg <= hitLatch ? wData_reg[15:0] : {wrLatch_reg[15:8], wData_reg[15:8]};
        end
      end else if (startWr && !abortWr) begin
        wrLatch_reg <= wrWord;
      end
    end
  end

  // ****************************************************************
  // Interrupt interaction
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqEn_reg    <= IRQ_RESET;
      irqFlag_reg  <= IRQ_RESET;
      glbIntDis_reg <= 1'b0;
      vectorBranch  <= 1'b0;
    end else begin
      vectorBranch <= endLong && !glbIntDis_reg;
      if (hitIrq) begin
        irqEn_reg     <= wData_reg[3:0];
        glbIntDis_reg <= wData_reg[IRQ_GLD_BIT];
      end
      if (abortWr || endLong) begin
        irqFlag_reg <= (irqFlag_reg & ~coreClr) | irqFlagSet;
      end else if (hitIrq) begin
        irqFlag_reg <= (irqFlag_reg & ~wData_reg[IRQ_FLAG_LSB +: 4]) | irqFlagSet;
      end else begin
        irqFlag_reg <= irqFlag_reg | irqFlagSet;
      end
    end
  end

  // ****************************************************************
  // Memory strobes
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memAddr         <= 16'h0000;
      memWdata        <= 16'h0000;
      memRd           <= 1'b0;
      memWrIntern     <= 1'b0;
      memWrExtern     <= 1'b0;
      executionHalted <= 1'b0;
    end else begin
      memAddr     <= ptr_reg;
      memWdata    <= startWr ? wrWord : wrLatch_reg;
      memRd       <= startRd;
      memWrIntern <= (state_next == ST_LONG);
      memWrExtern <= (state_reg == ST_SHORT) && ext_reg && (state_next == ST_DONE);
      executionHalted <= (state_next != ST_IDLE);
    end
  end

endmodule : pmta_core

// ===== verif/pmta_chk.sv
// Port checks for the table access unit.
// Assumes a bind into pmta_core, one clock domain.
`timescale 1ns/1ps
module pmta_chk
  import pmta_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [15:0] memAddr,
  input wire logic        memRd,
  input wire logic        memWrIntern,
  input wire logic        memWrExtern,
  input wire logic        executionHalted,
  input wire logic        vectorBranch
);
  // ************************************
  // Assertions
  // ************************************
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  a_long_halts: assert property (memWrIntern |-> executionHalted)
    else $error("long write without halt");
  a_long_addr: assert property (memWrIntern && $past(memWrIntern) |-> $stable(memAddr))
    else $error("address moved in long write");
  a_vector_cause: assert property (vectorBranch |-> !memWrIntern && $past(memWrIntern))
    else $error("vector without long write end");
  a_vector_pulse: assert property (vectorBranch |=> !vectorBranch)
    else $error("vector held");
  a_ext_short: assert property (memWrExtern |-> executionHalted && !memWrIntern ##1 !memWrExtern)
    else $error("external write not short");
  a_fetch_once: assert property (memRd |-> executionHalted ##1 !memRd)
    else $error("fetch not single");
  a_fetch_apart: assert property (memRd |-> !memWrIntern && !memWrExtern)
    else $error("fetch during write");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  c_long_end: cover property ($fell(memWrIntern));
  c_vector: cover property (vectorBranch);
  c_ext: cover property (memWrExtern);
endmodule : pmta_chk
bind pmta_core pmta_chk i_pmta_chk (.clk, .rst, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .memAddr, .memRd, .memWrIntern, .memWrExtern, .executionHalted, .vectorBranch);

// ===== verif/pmta_mem_model.sv
// Program memory model for table reads and writes.
// Assumes memAddr is valid while a strobe is high; reads answer in the same cycle.
`timescale 1ns/1ps
module pmta_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  input  wire logic        memRd,
  input  wire logic        memWrIntern,
  input  wire logic        memWrExtern,
  output logic      [15:0] memRdata
);
  // ************************************
  // Storage
  // ************************************
  logic [15:0] mem [0:65535];
  // Inverse data while not read, so a mistimed fetch shows up
  assign memRdata = memRd ? mem[memAddr] : ~mem[memAddr];
  always @(posedge clk) begin
    if (memWrIntern || memWrExtern) begin
      mem[memAddr] <= memWdata;
    end
  end
endmodule : pmta_mem_model

// ===== verif/tb.sv
// Self-checking bench for the table access unit.
// Assumes pmta_core, the memory model and the bound checker.
`timescale 1ns/1ps
module tb;
  import pmta_pkg::*;
  logic        clk, rst, programmingVoltage, memRd, memWrIntern, memWrExtern;
  logic        executionHalted, vectorBranch, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, irqFlagSet;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] memAddr, memWdata, memRdata;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  int          errorCnt, checksDone, vecCnt, extCnt, longCyc;
  pmta_core i_pmta_core (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .programmingVoltage, .irqFlagSet, .memAddr, .memWdata,
    .memRdata, .memRd, .memWrIntern, .memWrExtern, .executionHalted, .vectorBranch);
  pmta_mem_model i_pmta_mem_model (.clk, .memAddr, .memWdata, .memRd, .memWrIntern,
    .memWrExtern, .memRdata);
  // ************************************
  // Clock, monitors and bus tasks
  // ************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (vectorBranch === 1'b1) vecCnt <= vecCnt + 1;
    if (memWrExtern === 1'b1) extCnt <= extCnt + 1;
    if (memWrIntern === 1'b1) longCyc <= longCyc + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic tmo(input int n);
    if (n >= 64) begin
      errorCnt++;
      final_report();
    end
  endtask : tmo
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic b, aw, w;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      b = s_axi_bvalid;
      r = s_axi_bresp;
      aw = s_axi_awready;
      w = s_axi_wready;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      n++;
    end while (b !== 1'b1 && n < 64);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk({30'h0, r}, {30'h0, AXI_OKAY});
  endtask : axw
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    logic v, ar;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      v = s_axi_rvalid & s_axi_rready;
      rdv = s_axi_rdata;
      r = s_axi_rresp;
      ar = s_axi_arready;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
      if (n == 2) s_axi_rready <= 1'b1;
    end while (v !== 1'b1 && n < 64);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk({30'h0, r}, {30'h0, er});
    chk(rdv & m, e);
  endtask : rd
  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, 32'h0, 32'h0, AXI_OKAY);
      n++;
    end while (rdv[0] !== 1'b0 && n < 64);
    tmo(n);
  endtask : idle
  task automatic cmd(input logic [31:0] c);
    axw(ADDR_CMD, c);
    idle();
  endtask : cmd
  task automatic pulse(input int i);
    @(posedge clk);
    irqFlagSet <= 4'h1 << i;
    @(posedge clk);
    irqFlagSet <= 4'h0;
  endtask : pulse
  task automatic longwr(input logic [31:0] irq, input int junk, input int src);
    axw(ADDR_IRQ, irq);
    axw(ADDR_CMD, 32'h0f03);
    pulse(junk);
    repeat (6) @(posedge clk);
    chk(32'(executionHalted), 32'h1);
    pulse(src);
    idle();
  endtask : longwr
  // ************************************
  // Scenarios
  // ************************************
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    programmingVoltage = 1'b0;
    irqFlagSet = 4'h0;
    i_pmta_mem_model.mem[16'hffff] = 16'hbeef;
    i_pmta_mem_model.mem[16'h0000] = 16'h1234;
    i_pmta_mem_model.mem[16'h0001] = 16'hc3c3;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_IRQ, 32'h1ff, 32'h0, AXI_OKAY);
    rd(ADDR_CMD, 32'h0, 32'h0, AXI_SLVERR);
    rd(8'h1c, 32'h0, 32'h0, AXI_SLVERR);
    axw(ADDR_PTR_LOW, 32'hff);
    axw(ADDR_PTR_HIGH, 32'hff);
    cmd(32'h0a);
    rd(ADDR_RDDATA, 32'hff, 32'h00, AXI_OKAY);
    rd(ADDR_PTR_HIGH, 32'hff, 32'h00, AXI_OKAY);
    cmd(32'h06);
    rd(ADDR_RDDATA, 32'hff, 32'hbe, AXI_OKAY);
    rd(ADDR_PTR_LOW, 32'hff, 32'h00, AXI_OKAY);
    cmd(32'h02);
    rd(ADDR_RDDATA, 32'hff, 32'h34, AXI_OKAY);
    axw(ADDR_LATCH, 32'h5aa5);
    cmd(32'h961b);
    chk(i_pmta_mem_model.mem[0], 32'h5a96);
    cmd(32'h12);
    cmd(32'h7715);
    cmd(32'h3c13);
    chk(i_pmta_mem_model.mem[1], 32'h773c);
    chk(extCnt, 2);
    cmd(32'h03);
    chk(i_pmta_mem_model.mem[1], 32'h773c);
    chk(longCyc, 0);
    programmingVoltage <= 1'b1;
    axw(ADDR_IRQ, 32'h001);
    pulse(0);
    cmd(32'h03);
    rd(ADDR_IRQ, 32'hf0, 32'h00, AXI_OKAY);
    chk(longCyc, 0);
    axw(ADDR_LATCH, 32'h0f0f);
    longwr(32'h1f8, 1, 3);
    chk(vecCnt, 0);
    rd(ADDR_IRQ, 32'h80, 32'h80, AXI_OKAY);
    chk(i_pmta_mem_model.mem[1], 32'h0f0f);
    cmd(32'h02);
    cmd(32'h02);
    rd(ADDR_RDDATA, 32'hff, 32'h0f, AXI_OKAY);
    longwr(32'h0f1, 3, 0);
    chk(vecCnt, 1);
    rd(ADDR_IRQ, 32'h10, 32'h00, AXI_OKAY);
    longwr(32'h0f8, 0, 3);
    chk(vecCnt, 2);
    rd(ADDR_IRQ, 32'h80, 32'h80, AXI_OKAY);
    longwr(32'h1f5, 3, 2);
    chk(vecCnt, 2);
    rd(ADDR_IRQ, 32'h40, 32'h00, AXI_OKAY);
    final_report();
  end
endmodule : tb
